// ### tps_pkg.sv
// Constants and types shared by the three-channel PWM sequencer
package tps_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL_STATUS = 8'h30;
	localparam logic [7:0] ADDR_PORT_BASE   = 8'h38;
	localparam logic [7:0] CTRL_RESET       = 8'h00;
	localparam int         RUN_LSB          = 0;
	localparam int         BAD_LSB          = 3;
	localparam int         EXT_ON_BIT       = 6;
	localparam int         EXT_DIR_BIT      = 7;
	localparam logic [7:0] PORT_RESET       = 8'h00;

	// ----------------------------------------------------------------
	// Sequencer shape
	// ----------------------------------------------------------------
	localparam int         NUM_CHAN         = 3;
	localparam int         PROG_DEPTH       = 64;
	localparam int         PROG_AW          = 6;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         SYS_CLK_HZ       = 125_000_000;
	localparam int         PRIM_CLK_HZ      = 32_768;
	localparam int         PRIM_DIV         = SYS_CLK_HZ / PRIM_CLK_HZ;
	localparam logic [9:0] PRESCALE_LO_DIV  = 10'h010;
	localparam logic [9:0] PRESCALE_HI_DIV  = 10'h200;

	// ----------------------------------------------------------------
	// Instruction fields
	// ----------------------------------------------------------------
	localparam int         OP_MSB           = 15;
	localparam int         OP_LSB           = 13;
	localparam int         PRESCALE_BIT     = 14;
	localparam int         STEP_MSB         = 13;
	localparam int         STEP_LSB         = 8;
	localparam int         SIGN_BIT         = 7;
	localparam int         INC_MSB          = 6;
	localparam logic [7:0] LOAD_HIGH_BYTE   = 8'h40;

	typedef enum logic [2:0] {
		TPS_OP_RAMP, TPS_OP_LOAD, TPS_OP_RESTART, TPS_OP_BRANCH,
		TPS_OP_END, TPS_OP_TRIGGER, TPS_OP_BAD
	} tps_op_t;

	typedef enum logic [1:0] {
		TPS_ST_HELD  = 2'b00,
		TPS_ST_FETCH = 2'b01,
		TPS_ST_EXEC  = 2'b11
	} tps_state_t;

endpackage

// ### tps_seq.sv
// Three-channel PWM sequencer with byte register port and external trigger pin
`timescale 1ns/1ps

// Notes on behaviour
// RL1 - Bits 0..2 run channels; zero holds reset
// RL2 - Program port accepts bytes only while held
// RL3 - Bad opcode sets status bit, resets channel
// RL4 - Bit 6 enables external trigger pin
// RL5 - Bit 7: 0 high input, 1 low output
// RL6 - Program port address auto-increments after each low byte
// RL7 - Three channels, each with its port
// RL8 - Instruction arrives high byte then low
// RL9 - Port reads give high then low byte
// RL10 - Each channel runs up to 64 instructions
// RL11 - Top three bits select the operation
// RL12 - Ramp starts count; compare drives output
// RL13 - Prescale bit divides by 16 or 512
// RL14 - Step lasts step-time prescaled periods
// RL15 - Sign zero counts up, one down
// RL16 - Increment field gives number of steps
// RL17 - PWM count is eight bits wide
// RL18 - Control register at 0x30, status bits 3..5
// RL19 - Port writes while running are ignored
module tps_seq #(
	parameter int PRIM_DIV = tps_pkg::PRIM_DIV
) (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic      [2:0] pwm_out,
	input  wire logic       trig_in,
	output logic            trig_out,
	output logic            trig_oe,
	output logic            trig_seen
);

	localparam int NC = tps_pkg::NUM_CHAN;
	localparam int AW = tps_pkg::PROG_AW;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic tps_pkg::tps_op_t op_of(input logic [15:0] insn);
		tps_pkg::tps_op_t op;
		case (insn[tps_pkg::OP_MSB:tps_pkg::OP_LSB]) // see RL11
			3'h4: op = tps_pkg::TPS_OP_BAD;
			3'h5: op = tps_pkg::TPS_OP_BRANCH;
			3'h6: op = tps_pkg::TPS_OP_END;
			3'h7: op = tps_pkg::TPS_OP_TRIGGER;
			default: op = (insn == 16'h0000) ? tps_pkg::TPS_OP_RESTART :
			              (insn[15:8] == tps_pkg::LOAD_HIGH_BYTE) ? tps_pkg::TPS_OP_LOAD :
			              tps_pkg::TPS_OP_RAMP;
		endcase
		return op;
	endfunction

	function automatic int port_index(input logic [7:0] addr);
		return (addr >= tps_pkg::ADDR_PORT_BASE && addr < tps_pkg::ADDR_PORT_BASE + 8'(NC))
		       ? int'(addr - tps_pkg::ADDR_PORT_BASE) : -1;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [NC-1:0]      run_q;
	logic [NC-1:0]      bad_q;
	logic               ext_on_q;
	logic               ext_dir_q;
	logic [15:0]        prog_q [NC][tps_pkg::PROG_DEPTH];
	logic [AW-1:0]      ptr_q [NC];
	logic [NC-1:0]      lo_q;
	logic [7:0]         hi_byte_q [NC];
	logic [NC-1:0]      run_prev_q;
	tps_pkg::tps_state_t st_q [NC];
	logic [AW-1:0]      pc_q [NC];
	logic [15:0]        ir_q [NC];
	logic [6:0]         inc_left_q [NC];
	logic [8:0]         pre_cnt_q [NC];
	logic [5:0]         step_cnt_q [NC];
	logic [7:0]         cnt_q [NC];
	logic [NC-1:0]      active_q;
	logic [15:0]        prim_cnt_q;
	logic               prim_tick_q;
	logic [7:0]         ref_q;
	logic               trig_meta_q;
	logic               trig_sync_q;
	logic [NC-1:0]      halt;
	logic [NC-1:0]      bad_hit;
	int                 wr_idx;
	int                 rd_idx;
	assign wr_idx = port_index(reg_addr);
	assign rd_idx = port_index(reg_addr);

	always_comb begin
		for (int c = 0; c < NC; c++) begin
			halt[c]    = 1'b0;
			bad_hit[c] = 1'b0;
			if (st_q[c] == tps_pkg::TPS_ST_EXEC && run_q[c]) begin
				bad_hit[c] = (op_of(ir_q[c]) == tps_pkg::TPS_OP_BAD); // see RL3
				halt[c]    = bad_hit[c] || (op_of(ir_q[c]) == tps_pkg::TPS_OP_END);
			end
		end
	end

	// ----------------------------------------------------------------
	// Control and status register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_q     <= '0;
			bad_q     <= '0;
			ext_on_q  <= 1'b0;
			ext_dir_q <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == tps_pkg::ADDR_CTRL_STATUS) begin // see RL18
				run_q     <= reg_wdata[tps_pkg::RUN_LSB +: NC]; // see RL1
				ext_on_q  <= reg_wdata[tps_pkg::EXT_ON_BIT]; // see RL4
				ext_dir_q <= reg_wdata[tps_pkg::EXT_DIR_BIT]; // see RL5
				bad_q     <= bad_q & ~reg_wdata[tps_pkg::RUN_LSB +: NC];
			end
			for (int c = 0; c < NC; c++) begin
				if (halt[c]) begin
					run_q[c] <= 1'b0; // see RL3
				end
				if (bad_hit[c]) begin
					bad_q[c] <= 1'b1; // see RL3
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Program ports
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lo_q       <= '0;
			run_prev_q <= '0;
			for (int c = 0; c < NC; c++) begin
				ptr_q[c]     <= '0;
				hi_byte_q[c] <= tps_pkg::PORT_RESET;
				for (int a = 0; a < tps_pkg::PROG_DEPTH; a++) begin
					prog_q[c][a] <= '0;
				end
			end
		end else begin
			run_prev_q <= run_q;
			for (int c = 0; c < NC; c++) begin
				if (run_q[c] && !run_prev_q[c]) begin
					ptr_q[c] <= '0;
					lo_q[c]  <= 1'b0;
				end else if (!run_q[c] && wr_idx == c && (reg_wr || reg_rd)) begin // see RL2, RL19
					lo_q[c] <= !lo_q[c]; // see RL6
					if (reg_wr && !lo_q[c]) begin
						hi_byte_q[c] <= reg_wdata; // see RL8
					end
					if (reg_wr && lo_q[c]) begin
						prog_q[c][ptr_q[c]] <= {hi_byte_q[c], reg_wdata}; // see RL8
					end
					if (lo_q[c]) begin
						ptr_q[c] <= ptr_q[c] + 1'b1; // see RL10
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == tps_pkg::ADDR_CTRL_STATUS) begin
				reg_rdata <= {ext_dir_q, ext_on_q, bad_q, run_q};
			end else if (rd_idx >= 0 && !run_q[rd_idx]) begin
				reg_rdata <= lo_q[rd_idx] ? prog_q[rd_idx][ptr_q[rd_idx]][7:0]
				                          : prog_q[rd_idx][ptr_q[rd_idx]][15:8]; // see RL9
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Primary clock enable and PWM reference
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prim_cnt_q  <= '0;
			prim_tick_q <= 1'b0;
			ref_q       <= 8'h00;
		end else begin
			prim_tick_q <= (prim_cnt_q == 16'(PRIM_DIV - 1));
			if (prim_cnt_q == 16'(PRIM_DIV - 1)) begin
				prim_cnt_q <= '0;
			end else begin
				prim_cnt_q <= prim_cnt_q + 1'b1;
			end
			if (prim_tick_q) begin
				ref_q <= ref_q + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel execution
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			active_q <= '0;
			for (int c = 0; c < NC; c++) begin
				st_q[c]       <= tps_pkg::TPS_ST_HELD;
				pc_q[c]       <= '0;
				ir_q[c]       <= '0;
				inc_left_q[c] <= '0;
				pre_cnt_q[c]  <= '0;
				step_cnt_q[c] <= '0;
				cnt_q[c]      <= 8'h00;
			end
		end else begin
			for (int c = 0; c < NC; c++) begin
				if (!run_q[c]) begin // see RL1
					st_q[c]     <= tps_pkg::TPS_ST_HELD;
					pc_q[c]     <= '0;
					cnt_q[c]    <= 8'h00;
					active_q[c] <= 1'b0;
				end else begin
					case (st_q[c])
						tps_pkg::TPS_ST_HELD: begin
							st_q[c] <= tps_pkg::TPS_ST_FETCH;
						end
						tps_pkg::TPS_ST_FETCH: begin
							ir_q[c]       <= prog_q[c][pc_q[c]]; // see RL10
							inc_left_q[c] <= prog_q[c][pc_q[c]][tps_pkg::INC_MSB:0]; // see RL16
							pc_q[c]       <= pc_q[c] + 1'b1;
							pre_cnt_q[c]  <= '0;
							step_cnt_q[c] <= '0;
							st_q[c]       <= tps_pkg::TPS_ST_EXEC;
						end
						tps_pkg::TPS_ST_EXEC: begin
							case (op_of(ir_q[c]))
								tps_pkg::TPS_OP_RESTART: begin
									pc_q[c] <= '0;
									st_q[c] <= tps_pkg::TPS_ST_FETCH;
								end
								tps_pkg::TPS_OP_LOAD: begin
									cnt_q[c]    <= ir_q[c][7:0];
									active_q[c] <= 1'b1;
									st_q[c]     <= tps_pkg::TPS_ST_FETCH;
								end
								tps_pkg::TPS_OP_RAMP: begin
									active_q[c] <= 1'b1; // see RL12
									if (inc_left_q[c] == '0) begin
										st_q[c] <= tps_pkg::TPS_ST_FETCH; // see RL16
									end else if (ramp_step(c)) begin
										inc_left_q[c] <= inc_left_q[c] - 1'b1;
										step_cnt_q[c] <= '0;
										if (!ir_q[c][tps_pkg::SIGN_BIT] && cnt_q[c] != 8'hFF) begin
											cnt_q[c] <= cnt_q[c] + 1'b1; // see RL15, RL17
										end else if (ir_q[c][tps_pkg::SIGN_BIT] && cnt_q[c] != 8'h00) begin
											cnt_q[c] <= cnt_q[c] - 1'b1; // see RL15, RL17
										end
									end else if (pre_tick(c)) begin
										step_cnt_q[c] <= step_cnt_q[c] + 1'b1; // see RL14
									end
									if (prim_tick_q) begin
										pre_cnt_q[c] <= pre_tick(c) ? 9'h000 : pre_cnt_q[c] + 1'b1; // see RL13
									end
								end
								tps_pkg::TPS_OP_END, tps_pkg::TPS_OP_BAD: begin
									st_q[c] <= tps_pkg::TPS_ST_EXEC;
								end
								default: begin
									st_q[c] <= tps_pkg::TPS_ST_FETCH;
								end
							endcase
						end
						default: begin
							st_q[c] <= tps_pkg::TPS_ST_HELD;
						end
					endcase
				end
			end
		end
	end

	function automatic logic pre_tick(input int c);
		logic [9:0] div;
		div = ir_q[c][tps_pkg::PRESCALE_BIT] ? tps_pkg::PRESCALE_HI_DIV : tps_pkg::PRESCALE_LO_DIV;
		return prim_tick_q && ({1'b0, pre_cnt_q[c]} == div - 10'h001); // see RL13
	endfunction

	function automatic logic ramp_step(input int c);
		logic [5:0] stime;
		stime = ir_q[c][tps_pkg::STEP_MSB:tps_pkg::STEP_LSB];
		return (stime == 6'h00) || (pre_tick(c) && step_cnt_q[c] == stime - 6'h01); // see RL14
	endfunction

	// ----------------------------------------------------------------
	// PWM outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_out <= '0;
		end else begin
			for (int c = 0; c < NC; c++) begin
				pwm_out[c] <= active_q[c] && (ref_q < cnt_q[c]); // see RL12, RL7
			end
		end
	end

	// ----------------------------------------------------------------
	// External trigger pin
	// ----------------------------------------------------------------
	// Output idles high since it is active low
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			trig_meta_q <= 1'b0;
			trig_sync_q <= 1'b0;
			trig_seen   <= 1'b0;
			trig_oe     <= 1'b0;
			trig_out    <= 1'b1;
		end else begin
			trig_meta_q <= trig_in;
			trig_sync_q <= trig_meta_q;
			trig_seen   <= ext_on_q && !ext_dir_q && trig_sync_q; // see RL4, RL5
			trig_oe     <= ext_on_q && ext_dir_q; // see RL4, RL5
			trig_out    <= 1'b1;
		end
	end

endmodule // tps_seq

// ### tps_seq_asserts.sv
// Port assertions for the three-channel PWM sequencer
`timescale 1ns/1ps
module tps_seq_chk (
	input wire logic       sys_clk,
	input wire logic       arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] pwm_out,
	input wire logic       trig_in,
	input wire logic       trig_out,
	input wire logic       trig_oe,
	input wire logic       trig_seen
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic [7:0] ctl_q;
	// ----------------------------------------------------------------
	// Shadow of the host-written control byte
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			ctl_q <= 8'h00;
		else if (reg_wr && reg_addr == 8'h30)
			ctl_q <= reg_wdata;
	end
	AST_TRIG_IDLE: assert property (trig_out)
		else $error("trigger output left its idle level");
	AST_OE_ON: assert property ((ctl_q[7:6] == 2'h3)[*2] |-> trig_oe)
		else $error("trigger pin not driven as output");
	AST_OE_OFF: assert property ((ctl_q[7:6] != 2'h3)[*2] |-> !trig_oe)
		else $error("trigger pin driven while not an output");
	AST_SEEN: assert property (trig_seen |-> $past(trig_in, 3) && $past(ctl_q[6]) && !$past(ctl_q[7]))
		else $error("trigger seen without enabled high input");
	AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	AST_CTL_RD: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata[7:6] == ctl_q[7:6])
		else $error("control read mismatch on trigger bits");
	AST_UNMAP: assert property (reg_rd && !(reg_addr inside {8'h30, 8'h38, 8'h39, 8'h3A}) |=> reg_rdata == 8'h00)
		else $error("unmapped read returned data");
	AST_HELD_DARK: assert property ((ctl_q[2:0] == 3'h0)[*3] |-> pwm_out == 3'h0)
		else $error("held channel drives its output");
	AST_RUN_PORT: assert property (reg_rd && reg_addr == 8'h38 && ctl_q[0] |=> reg_rdata == 8'h00)
		else $error("port read while running returned data");
endmodule // tps_seq_chk

bind tps_seq tps_seq_chk u_chk (.sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
	.pwm_out, .trig_in, .trig_out, .trig_oe, .trig_seen);

// ### tps_host.sv
// Host bus master model driving the register strobes
`timescale 1ns/1ps
module tps_host (
	input  wire logic       sys_clk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// Strobe stays up so writes can run back to back
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_rd = 1'b0;
		reg_wr = 1'b1;
		@(posedge sys_clk);
	endtask
	// Strobes drop low; address and data lines show the inverse of their last value
	task automatic idle();
		#1 reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		#1 reg_addr = a;
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(posedge sys_clk);
		#1 reg_rd = 1'b0;
		d = reg_rdata;
		@(posedge sys_clk);
	endtask
endmodule // tps_host

// ### test_three_channel_pwm_sequencer.sv
// Self-checking bench for the three-channel PWM sequencer
`timescale 1ns/1ps
module test_three_channel_pwm_sequencer;
	localparam int DIV = 4;
	logic        sys_clk, arst_n, reg_wr, reg_rd, trig_in, trig_out, trig_oe, trig_seen;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_v, ctl;
	logic [2:0]  pwm_out;
	logic [15:0] prog [3][$];
	int          fails, compares, hi0, hi1;

	tps_seq #(.PRIM_DIV(DIV)) u_dut (.sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .pwm_out, .trig_in, .trig_out, .trig_oe, .trig_seen);
	tps_host u_host (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Count after a ramp from start s, saturating at the ends
	function automatic int ramp_end(int s, logic [15:0] w);
		int v;
		v = w[7] ? s - int'(w[6:0]) : s + int'(w[6:0]);
		return v < 0 ? 0 : (v > 255 ? 255 : v);
	endfunction

	initial begin
		#(8 * 30000);
		fails++;
		complete_run();
	end

	initial begin
		trig_in = 1'b0;
		arst_n = 1'b0;
		hi0 = $urandom(32'h32B9);
		repeat (5) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		@(posedge sys_clk);
		u_host.rd(8'h30, rd_v);
		cmp(rd_v, 8'h00);
		u_host.rd(8'h3B, rd_v);
		cmp(rd_v, 8'h00);
		// ----------------------------------------------------------------
		// Trigger pin in all four modes
		// ----------------------------------------------------------------
		for (int m = 0; m < 4; m++) begin
			ctl = {2'(m), 6'h00};
			u_host.wr(8'h30, ctl);
			u_host.rd(8'h30, rd_v);
			cmp(rd_v, ctl);
			#1 trig_in = (m == 1) ? 1'b1 : 1'($urandom);
			repeat (5) @(negedge sys_clk);
			cmp({trig_oe, trig_seen, trig_out}, {m == 3, m == 1 && trig_in, 1'b1});
			@(posedge sys_clk);
			#1 trig_in = 1'b0;
			repeat (4) @(posedge sys_clk);
		end
		// ----------------------------------------------------------------
		// Load programs while held, then run all three
		// ----------------------------------------------------------------
		prog[0] = '{16'h40C8, 16'h0183, 16'h7F01, 16'($urandom) & 16'h7FFF};
		prog[1] = '{16'h0104, 16'h7F01, 16'($urandom) & 16'h7FFF};
		prog[2] = '{16'h0004, 16'h8000, 16'($urandom) & 16'h7FFF};
		for (int c = 0; c < 3; c++) begin
			for (int i = 0; i < prog[c].size(); i++) begin
				u_host.wr(8'h38 + 8'(c), prog[c][i][15:8]);
				u_host.wr(8'h38 + 8'(c), prog[c][i][7:0]);
			end
		end
		u_host.wr(8'h30, ctl | 8'h07);
		u_host.idle();
		repeat (10) @(posedge sys_clk);
		u_host.rd(8'h30, rd_v);
		cmp(rd_v, ctl | 8'h23);
		u_host.rd(8'h38, rd_v);
		cmp(rd_v, 8'h00);
		u_host.wr(8'h38, 8'($urandom));
		u_host.wr(8'h38, 8'($urandom));
		u_host.idle();
		repeat (600) @(posedge sys_clk);
		hi0 = 0;
		hi1 = 0;
		repeat (1024) begin
			@(negedge sys_clk);
			hi0 += int'(pwm_out[0]);
			hi1 += int'(pwm_out[1]);
		end
		cmp(16'(hi0), 16'(ramp_end(int'(prog[0][0][7:0]), prog[0][1]) * DIV));
		cmp(16'(hi1), 16'(ramp_end(0, prog[1][0]) * DIV));
		@(posedge sys_clk);
		u_host.wr(8'h30, ctl);
		u_host.idle();
		repeat (4) @(negedge sys_clk);
		cmp(pwm_out, 3'h0);
		@(posedge sys_clk);
		// ----------------------------------------------------------------
		// Read every program back, high byte first
		// ----------------------------------------------------------------
		for (int c = 0; c < 3; c++) begin
			for (int i = 0; i < prog[c].size(); i++) begin
				u_host.rd(8'h38 + 8'(c), rd_v);
				cmp(rd_v, prog[c][i][15:8]);
				u_host.rd(8'h38 + 8'(c), rd_v);
				cmp(rd_v, prog[c][i][7:0]);
			end
		end
		complete_run();
	end
endmodule // test_three_channel_pwm_sequencer
